// file: rtl/t2rc_pkg.sv
// package: register map, field layout and types of the reload/compare timer
package t2rc_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL = 8'hc8; // timer_control_register
    localparam logic [7:0] IDX_MODE = 8'hc9; // timer_mode_control
    localparam logic [7:0] IDX_RCL  = 8'hca; // reload_compare_low
    localparam logic [7:0] IDX_RCH  = 8'hcb; // reload_compare_high
    localparam logic [7:0] IDX_CNTL = 8'hcc; // count_low_byte
    localparam logic [7:0] IDX_CNTH = 8'hcd; // count_high_byte
    localparam logic [7:0] IDX_STAT = 8'hd0; // event status, read only
    localparam logic [7:0] IDX_CLR  = 8'hd1; // event clear, write one to clear
    localparam logic [7:0] IDX_IEN  = 8'hd2; // event interrupt enable

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_FLAG_BIT = 7; // overflow_match_flag
    localparam int CTRL_RUN_BIT  = 2; // run_control
    localparam int CTRL_MODE_BIT = 0; // compare_reload_select
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_MAX  = 16'hffff;

    // event bits, shared by status, clear and enable registers
    localparam int NUM_EVT   = 3;
    localparam int EVT_OVF   = 0;
    localparam int EVT_MATCH = 1;
    localparam int EVT_RLD   = 2;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

    // reload trigger encodings
    typedef enum logic [1:0] {
        TRIG_OVF  = 2'b00,
        TRIG_CAP0 = 2'b01,
        TRIG_CAP1 = 2'b10,
        TRIG_CAP2 = 2'b11
    } t2rc_trig_t;

    // mode register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       reload_enable;         // bit 7
        logic [2:0] prescale_select;       // bits 6:4
        logic       capture_auto_clear;    // bit 3
        logic       match_auto_clear;      // bit 2
        t2rc_trig_t reload_trigger_select; // bits 1:0
    } t2rc_mode_t;

    // address phase captured for the following data phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] idx;
    } t2rc_req_t;

    // prescaler mask: a tick fires when the low bits of the divider are all ones
    function automatic logic [8:0] t2rc_div_mask(input logic [2:0] sel);
        case (sel)
            3'h0: t2rc_div_mask = 9'h000;
            3'h1: t2rc_div_mask = 9'h003;
            3'h2: t2rc_div_mask = 9'h00f;
            3'h3: t2rc_div_mask = 9'h01f;
            3'h4: t2rc_div_mask = 9'h03f;
            3'h5: t2rc_div_mask = 9'h07f;
            3'h6: t2rc_div_mask = 9'h0ff;
            default: t2rc_div_mask = 9'h1ff;
        endcase
    endfunction : t2rc_div_mask

endpackage : t2rc_pkg

// file: rtl/t2rc_timer.sv
// module: 16-bit reload/compare timer with AHB-Lite register slave
`timescale 1ns/1ns

// Operation
// R1: a reload happens only while reload_enable (mode bit 7) is one.
// R2: the tick divides clk by 1,4,16,32,64,128,256 or 512 per prescale_select.
// R3: in auto-reload mode with capture_auto_clear (bit 3) a capture zeroes the counter.
// R4: in compare mode with match_auto_clear (bit 2) a match zeroes the counter.
// R5: reload_trigger_select picks overflow or capture channel 0, 1 or 2.
// R6: the reload/compare pair is the compare value or the reload value by mode.
// R7: the counter is two byte registers, each readable and writable.
// R8: software should stop the timer before touching the counter bytes.
// R9: compare_reload_select at zero means auto-reload mode.
// R10: an enabled reload loads both counter bytes from the pair on its event.
// R11: with capture_auto_clear a capture only clears and never reloads.
// R12: in compare mode a count equal to the pair sets overflow_match_flag.
// R13: run_control low freezes the counter, high lets it advance on ticks; capture reloads and capture clears still act while it is low.
// R14: the flag is set by overflow or match and cleared only by software.
// R15: compare_reload_select is control bit 0, zero reload and one compare.
// R16: each tick adds one, wrapping from ffff to 0000 as the overflow event.
// R17: three single-cycle capture strobes drive capture reload and clear.
module t2rc_timer (
    input  wire  logic                 clk,
    input  wire  logic                 resetn,
    input  wire  logic                 hsel,
    input  wire  logic [31:0]          haddr,
    input  wire  logic [1:0]           htrans,
    input  wire  logic                 hwrite,
    input  wire  logic [2:0]           hsize,
    input  wire  logic [31:0]          hwdata,
    input  wire  logic                 hready,
    output logic       [31:0]          hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire  logic [2:0]           capture_event,
    output logic                       irq
);
    import t2rc_pkg::*;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    t2rc_req_t            req_q;
    logic [31:0]          hrdata_q;
    logic [7:0]           ctrl_q;
    t2rc_mode_t           mode_q;
    logic [15:0]          rc_q;
    logic [15:0]          cnt_q;
    logic [15:0]          cnt_d;
    logic [8:0]           pre_q;
    logic [NUM_EVT-1:0]   stat_q;
    logic [NUM_EVT-1:0]   stat_d;
    logic [NUM_EVT-1:0]   ien_q;
    logic                 irq_q;
    logic                 flag_d;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire       take    = hsel && hready && (htrans == HTRANS_NONSEQ);
    wire [7:0] a_idx   = haddr[9:2];
    wire       wr      = req_q.valid && req_q.write;
    wire       wr_ctrl = wr && (req_q.idx == IDX_CTRL);
    wire       wr_mode = wr && (req_q.idx == IDX_MODE);
    wire       wr_rcl  = wr && (req_q.idx == IDX_RCL);
    wire       wr_rch  = wr && (req_q.idx == IDX_RCH);
    wire       wr_cntl = wr && (req_q.idx == IDX_CNTL);
    wire       wr_cnth = wr && (req_q.idx == IDX_CNTH);
    wire       wr_clr  = wr && (req_q.idx == IDX_CLR);
    wire       wr_ien  = wr && (req_q.idx == IDX_IEN);
    wire       wr_cnt  = wr_cntl || wr_cnth;
    wire [7:0] wdat    = hwdata[7:0];

    // read mux, sampled in the address phase; unmapped and write-only read zero
    logic [7:0] rd_byte;
    always_comb begin
        if (a_idx == IDX_CTRL) begin
            rd_byte = ctrl_q;
        end else if (a_idx == IDX_MODE) begin
            rd_byte = mode_q;
        end else if (a_idx == IDX_RCL) begin
            rd_byte = rc_q[7:0];
        end else if (a_idx == IDX_RCH) begin
            rd_byte = rc_q[15:8];
        end else if (a_idx == IDX_CNTL) begin
            rd_byte = cnt_q[7:0]; // R7
        end else if (a_idx == IDX_CNTH) begin
            rd_byte = cnt_q[15:8]; // R7
        end else if (a_idx == IDX_STAT) begin
            rd_byte = {5'h00, stat_q};
        end else if (a_idx == IDX_IEN) begin
            rd_byte = {5'h00, ien_q};
        end else begin
            rd_byte = 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // counting engine
    // ------------------------------------------------------------------
    wire        run      = ctrl_q[CTRL_RUN_BIT];
    wire        is_cmp   = ctrl_q[CTRL_MODE_BIT]; // R15 R9
    wire [8:0]  mask     = t2rc_div_mask(mode_q.prescale_select);
    wire        tick     = run && ((pre_q & mask) == mask); // R2 R13
    wire        ovf      = tick && (cnt_q == CNT_MAX); // R16
    wire        match    = tick && is_cmp && (cnt_q == rc_q); // R12 R6
    wire        cap_any  = |capture_event; // R17
    wire [1:0]  trig     = mode_q.reload_trigger_select;
    wire        cap_sel  = (trig == TRIG_OVF) ? 1'b0 : capture_event[trig - 2'h1]; // R5
    wire        trig_hit = (trig == TRIG_OVF) ? ovf : (cap_sel && !mode_q.capture_auto_clear);
    wire        reload   = !is_cmp && mode_q.reload_enable && trig_hit; // R1 R10 R11
    wire        cap_clr  = !is_cmp && mode_q.capture_auto_clear && cap_any; // R3
    wire        mat_clr  = match && mode_q.match_auto_clear; // R4

    // software write wins, then clears, then reload, then increment;
    // a running counter written by software may lose a tick, hence stop first
    always_comb begin
        cnt_d = cnt_q;
        if (wr_cnt) begin
            if (wr_cntl) begin
                cnt_d[7:0] = wdat; // R7 R8
            end
            if (wr_cnth) begin
                cnt_d[15:8] = wdat; // R7 R8
            end
        end else if (cap_clr || mat_clr) begin
            cnt_d = CNT_ZERO; // R3 R4 R11
        end else if (reload) begin
            cnt_d = rc_q; // R10 R6
        end else if (tick) begin
            cnt_d = cnt_q + 16'h0001; // R16
        end
    end

    // hardware set wins over a software clear in the same cycle
    assign flag_d = ovf || match || (wr_ctrl ? wdat[CTRL_FLAG_BIT] : ctrl_q[CTRL_FLAG_BIT]); // R14

    // ------------------------------------------------------------------
    // sticky event status, one bit per event
    // ------------------------------------------------------------------
    wire [NUM_EVT-1:0] evt = {reload, match, ovf};
    // next enable value, so the interrupt never lags an enable write by a cycle
    wire [NUM_EVT-1:0] ien_d = wr_ien ? wdat[NUM_EVT-1:0] : ien_q;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVT; gi++) begin : g_stat
            assign stat_d[gi] = evt[gi] || (stat_q[gi] && !(wr_clr && wdat[gi]));
        end
    endgenerate

    // ------------------------------------------------------------------
    // bus registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            req_q    <= '0;
            hrdata_q <= 32'h0000_0000;
        end else begin
            req_q    <= '{valid: take, write: hwrite, idx: a_idx};
            hrdata_q <= (take && !hwrite) ? {24'h00_0000, rd_byte} : hrdata_q;
        end
    end

    // configuration registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= REG_RESET;
            mode_q <= t2rc_mode_t'(REG_RESET);
            rc_q   <= {REG_RESET, REG_RESET};
            ien_q  <= '0;
        end else begin
            ctrl_q <= wr_ctrl ? {flag_d, 4'h0, wdat[2], 1'b0, wdat[0]}
                              : {flag_d, ctrl_q[6:0]};
            mode_q <= wr_mode ? t2rc_mode_t'(wdat) : mode_q;
            rc_q   <= {wr_rch ? wdat : rc_q[15:8], wr_rcl ? wdat : rc_q[7:0]};
            ien_q  <= ien_d;
        end
    end

    // counter, prescaler, status and interrupt
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q  <= CNT_ZERO;
            pre_q  <= 9'h000;
            stat_q <= '0;
            irq_q  <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            pre_q  <= run ? pre_q + 9'h001 : 9'h000; // R13
            stat_q <= stat_d;
            irq_q  <= |(stat_d & ien_d); // tracks status and enable together
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = 1'b1; // zero wait states, always OKAY
    assign hresp     = 1'b0;
    assign irq       = irq_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    wire quiet = !wr_cnt && !cap_clr && !mat_clr;

    property p_r1;
        ovf && !mode_q.reload_enable && quiet |=> cnt_q == CNT_ZERO;
    endproperty
    a_r1: assert property (p_r1) else $error("reload while disabled"); // R1

    sequence s_div4;
        tick && mode_q.prescale_select == 3'h1 && !wr_mode
        ##1 (run && mode_q.prescale_select == 3'h1 && !wr_mode)[*4];
    endsequence
    property p_r2;
        s_div4 |-> tick && !$past(tick) && !$past(tick, 2);
    endproperty
    a_r2: assert property (p_r2) else $error("divide by four broken"); // R2

    property p_r3;
        cap_clr && !wr_cnt |=> cnt_q == CNT_ZERO;
    endproperty
    a_r3: assert property (p_r3) else $error("capture clear missed"); // R3

    property p_r4;
        match && mode_q.match_auto_clear && !wr_cnt |=> cnt_q == CNT_ZERO;
    endproperty
    a_r4: assert property (p_r4) else $error("match clear missed"); // R4

    property p_r5;
        !is_cmp && mode_q == 8'h82 && capture_event[1] && !wr_cnt
        |=> cnt_q == $past(rc_q);
    endproperty
    a_r5: assert property (p_r5) else $error("channel 1 reload missed"); // R5

    property p_r10;
        reload && quiet |=> cnt_q == $past(rc_q);
    endproperty
    a_r10: assert property (p_r10) else $error("reload value wrong"); // R10

    property p_r12;
        tick && is_cmp && cnt_q == rc_q |=> ctrl_q[CTRL_FLAG_BIT] && stat_q[EVT_MATCH];
    endproperty
    a_r12: assert property (p_r12) else $error("match flag not set"); // R12

    property p_r13;
        !run && !wr_cnt && !cap_clr && !reload |=> $stable(cnt_q);
    endproperty
    a_r13: assert property (p_r13) else $error("stopped counter moved"); // R13

    property p_r14;
        ctrl_q[CTRL_FLAG_BIT] && !wr_ctrl |=> ctrl_q[CTRL_FLAG_BIT];
    endproperty
    a_r14: assert property (p_r14) else $error("flag self cleared"); // R14

    property p_r16;
        tick && !reload && quiet |=> cnt_q == $past(cnt_q) + 16'h0001;
    endproperty
    a_r16: assert property (p_r16) else $error("increment wrong"); // R16

    property p_irq;
        |(stat_q & ien_q) |-> irq_q;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    // ------------------------------------------------------------------
    // further checks on counter bytes, modes and event bookkeeping
    // ------------------------------------------------------------------
    property p_r7;
        wr_cntl |=> cnt_q[7:0] == $past(wdat);
    endproperty
    a_r7: assert property (p_r7) else $error("low count byte write lost"); // R7

    property p_r11;
        !is_cmp && mode_q.reload_enable && mode_q.capture_auto_clear && cap_any && !wr_cnt
        |=> cnt_q == CNT_ZERO;
    endproperty
    a_r11: assert property (p_r11) else $error("capture reloaded under auto-clear"); // R11

    // compare mode must ignore capture strobes entirely
    property p_r15;
        is_cmp && cap_any && !tick && !wr_cnt |=> $stable(cnt_q);
    endproperty
    a_r15: assert property (p_r15) else $error("capture acted in compare mode"); // R15

    property p_r14s;
        ovf || match |=> ctrl_q[CTRL_FLAG_BIT];
    endproperty
    a_r14s: assert property (p_r14s) else $error("flag not set by event"); // R14

    property p_r16s;
        ovf |=> stat_q[EVT_OVF];
    endproperty
    a_r16s: assert property (p_r16s) else $error("overflow status not set"); // R16

    // a stopped prescaler restarts from zero, so the first tick is a full period
    property p_r13p;
        !run |=> pre_q == 9'h000;
    endproperty
    a_r13p: assert property (p_r13p) else $error("prescaler not held while stopped"); // R13

    property p_irq_low;
        !(|(stat_q & ien_q)) |-> !irq_q;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("interrupt without enabled status");

endmodule : t2rc_timer

// file: verif/tb.sv
// testbench: register-level tests of the reload/compare timer over AHB-Lite
`timescale 1ns/1ns
module tb;
    import t2rc_pkg::*;
    logic        clk, resetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize, capture_event;
    logic [7:0]  v, f;
    logic [15:0] c;
    int          mismatches, total_checks;
    localparam logic [7:0] IDX_NONE = 8'h10; // no register here
    logic [7:0]  idx_tab [8] = '{IDX_CTRL, IDX_MODE, IDX_RCL, IDX_RCH, IDX_CNTL,
                                 IDX_CNTH, IDX_STAT, IDX_IEN};

    // --------------------------------------------------------------
    // clock, reset and device
    // --------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    t2rc_timer i_dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .capture_event(capture_event), .irq(irq));

    // --------------------------------------------------------------
    // bus and check tasks
    // --------------------------------------------------------------
    // one single transfer; hready is sampled at each edge before moving on
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        chk(hresp, 1'b0);
        q = hrdata[7:0];
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(idx, 1'b1, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [7:0] q);
        bus(idx, 1'b0, 8'h00, q);
    endtask : rd

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // an unknown value fails the range test as well
    task automatic rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        total_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            mismatches++;
            $display("[FAIL] %0t got %h outside %h..%h", $time, got, lo, hi);
        end
    endtask : rng

    // counter bytes are only touched while the timer is stopped
    task automatic setcnt(input logic [15:0] x);
        wr(IDX_CNTL, x[7:0]);
        wr(IDX_CNTH, x[15:8]);
    endtask : setcnt

    task automatic rdcnt(output logic [15:0] q);
        logic [7:0] lo, hi;
        rd(IDX_CNTL, lo);
        rd(IDX_CNTH, hi);
        q = {hi, lo};
    endtask : rdcnt

    // run for k cycles, read control, then stop keeping the flag as read
    task automatic run(input logic [7:0] b, input int k);
        wr(IDX_CTRL, b | 8'h04);
        repeat (k) @(posedge clk);
        rd(IDX_CTRL, f);
        wr(IDX_CTRL, f & 8'hfb);
    endtask : run

    task automatic cap(input int i);
        @(posedge clk);
        capture_event <= 3'b001 << i;
        @(posedge clk);
        capture_event <= 3'b000;
    endtask : cap

    task automatic report_and_stop;
        if (mismatches == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    // --------------------------------------------------------------
    // watchdog: the prescaler sweep dominates, about 33k cycles
    // --------------------------------------------------------------
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        {resetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
        hsize = 3'b010;
        capture_event = 3'b000;
        mismatches = 0;
        total_checks = 0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        // reset values, read-only status, unmapped place
        foreach (idx_tab[i]) begin
            rd(idx_tab[i], v);
            chk(v, 16'h0000);
        end
        wr(IDX_STAT, 8'h07);
        rd(IDX_STAT, v);
        chk(v, 16'h0000);
        wr(IDX_NONE, 8'ha5);
        rd(IDX_NONE, v);
        chk(v, 16'h0000);
        // byte registers hold separate values
        for (int i = 2; i < 6; i++) begin
            wr(idx_tab[i], 8'h5a ^ i[7:0]);
            rd(idx_tab[i], v);
            chk(v, 16'h005a ^ i[15:0]);
        end
        // every divider: about 32 ticks, then the stopped count holds
        for (int s = 0; s < 8; s++) begin
            wr(IDX_MODE, s[7:0] << 4);
            setcnt(16'h0000);
            run(8'h00, 32 * (s == 0 ? 1 : (2 << (s + (s > 1 ? 1 : 0)))));
            rdcnt(c);
            rng(c, 16'd31, 16'd40);
            repeat (20) @(posedge clk);
            rd(IDX_CNTL, v);
            chk(v, c[7:0]);
        end
        // overflow with reload off: wraps to zero, flag, status and irq
        wr(IDX_MODE, 8'h00);
        wr(IDX_CLR, 8'h07);
        setcnt(16'hfffe);
        run(8'h00, 4);
        chk(f[7], 1'b1);
        rdcnt(c);
        rng(c, 16'h0001, 16'h0010);
        rd(IDX_STAT, v);
        chk(v, 16'h0001);
        chk(irq, 1'b0);
        wr(IDX_IEN, 8'h01);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        wr(IDX_CLR, 8'h01);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        rd(IDX_CTRL, v);
        chk(v, 16'h0080);
        wr(IDX_CTRL, 8'h00);
        rd(IDX_CTRL, v);
        chk(v, 16'h0000);
        // overflow reload from the pair
        wr(IDX_RCL, 8'h00);
        wr(IDX_RCH, 8'h80);
        wr(IDX_MODE, 8'h80);
        setcnt(16'hfffe);
        run(8'h00, 4);
        rdcnt(c);
        rng(c, 16'h8000, 16'h8010);
        rd(IDX_STAT, v);
        chk(v[2], 1'b1);
        // capture triggers: only the selected channel reloads
        for (int t = 1; t < 4; t++) begin
            wr(IDX_MODE, 8'h80 | t[7:0]);
            for (int i = 0; i < 3; i++) begin
                setcnt(16'h0011);
                cap(i);
                rdcnt(c);
                chk(c, (i == t - 1) ? 16'h8000 : 16'h0011);
            end
        end
        wr(IDX_MODE, 8'h01);
        setcnt(16'h0011);
        cap(0);
        rdcnt(c);
        chk(c, 16'h0011);
        // capture auto-clear zeroes instead of reloading, not in compare mode
        wr(IDX_MODE, 8'h89);
        setcnt(16'h0011);
        cap(0);
        rdcnt(c);
        chk(c, 16'h0000);
        wr(IDX_CTRL, 8'h01);
        setcnt(16'h0011);
        cap(0);
        rdcnt(c);
        chk(c, 16'h0011);
        // compare mode: match sets flag, counting goes on or clears
        wr(IDX_RCL, 8'h40);
        wr(IDX_RCH, 8'h00);
        wr(IDX_MODE, 8'h00);
        wr(IDX_CLR, 8'h07);
        setcnt(16'h0030);
        run(8'h01, 20);
        chk(f[7], 1'b1);
        rdcnt(c);
        rng(c, 16'h0041, 16'h0050);
        rd(IDX_STAT, v);
        chk(v[1], 1'b1);
        wr(IDX_CTRL, 8'h01);
        wr(IDX_MODE, 8'h04);
        setcnt(16'h0030);
        run(8'h01, 20);
        chk(f[7], 1'b1);
        rdcnt(c);
        rng(c, 16'h0000, 16'h0020);
        report_and_stop();
    end

endmodule : tb
